// ==== src/dmc_pkg.sv ====
// package of constants for the converter mode strap and control-pin logic
//
// How it works
// R01: strap low selects serial-port register mode; shared pins form the serial port.
// R02: strap high selects pin mode; settings come straight from the shared pins.
// R03: in serial mode a high strap pulse returns all serial registers to defaults.
// R04: in serial mode the shared clock-mode pin is the serial clock from host.
// R05: in serial mode the format pin is bidirectional data; host releases for reads.
// R06: in serial mode the shutdown pin is an active-low chip select.
// R07: host ties retime phase pin low when qualify and sampling clocks match.
// R08: with separate clocks a rising edge on retime phase pin triggers retiming.
// R09: in pin mode the retime phase pin sets the internal retime clock phase.
// R10: in pin mode format pin low means straight binary input word.
// R11: in pin mode format pin high means twos-complement input word.
// R12: in pin mode shutdown pin high powers down all but the serial port; the code zeroes only the true output, the complement output goes to all ones.
// R13: true I output carries full scale when every data bit is one.
// R14: complement I output carries full scale when every data bit is zero.
// R15: the parallel word is qualified by the separate data-qualifying clock.
// R16: data are sampled by a separate sampling clock, distinct from the qualifier.
// R17: in serial mode phase, format and shutdown come from serial registers.
package dmc_pkg;
  // ----------------------------------------------------------------
  // widths and serial frame layout
  // ----------------------------------------------------------------
  localparam int WORD_W     = 10;
  localparam int ADDR_W     = 5;
  localparam int SDATA_W    = 8;
  localparam int FRAME_W    = 1 + 2 + ADDR_W + SDATA_W;  // rw, len, addr, data
  localparam int SYNC_DEPTH = 3;
  // ----------------------------------------------------------------
  // control register: offset, field positions, reset value
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0]  CTRL_ADDR    = 5'h00;
  localparam int                 CTRL_PHASE_B = 0;
  localparam int                 CTRL_FMT_B   = 1;
  localparam int                 CTRL_PDN_B   = 2;
  localparam logic [SDATA_W-1:0] CTRL_RESET   = 8'h00;
  localparam logic [SDATA_W-1:0] CTRL_MASK    = 8'h07;
endpackage : dmc_pkg

// ==== src/dmc_sync.sv ====
// three-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module dmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // the agree test below is written for exactly three stages
  if (WIDTH < 1 || dmc_pkg::SYNC_DEPTH != 3) begin : g_bad_cfg
    $error("dmc_sync: unsupported width or depth");
  end

  // change accepted only once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int k = 0; k < WIDTH; k++) begin
      if (s2_q[k] == s3_q[k]) begin
        lvl_d[k] = s3_q[k];
      end
    end
  end

  // first stage is read by the second stage alone
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule : dmc_sync

// ==== src/dmc_ctrl.sv ====
// control-pin logic: mode strap, serial port, pin mode and output polarity
`timescale 1ns/1ps
module dmc_ctrl #(
  parameter int WORD_W = dmc_pkg::WORD_W
) (
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  input  wire logic              i_mode_strap_and_register_clear,
  input  wire logic              i_serial_clock_or_retime_phase,
  input  wire logic              i_format_data_in,
  output logic                   o_format_data_out,
  output logic                   o_format_data_oe_n,
  input  wire logic              i_select_or_shutdown_pin,
  input  wire logic              i_data_qualify_clock,
  input  wire logic [WORD_W-1:0] i_parallel_word,
  output logic      [WORD_W-1:0] o_i_channel_true_output,
  output logic      [WORD_W-1:0] o_i_channel_complement_output,
  output logic                   o_pin_strap_operation,
  output logic                   o_retime_phase,
  output logic                   o_twos_complement,
  output logic                   o_shutdown,
  output logic                   o_retime_trigger
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (WORD_W < 2 || WORD_W > 16) begin : g_bad_width
    $error("dmc_ctrl: WORD_W out of range");
  end

  // ----------------------------------------------------------------
  // pin synchronisers (strap, sclk, sdio, cs, qualify clock)
  // ----------------------------------------------------------------
  logic [4:0] pins;
  logic       strap, sclk, sdi, csn, dqclk;
  dmc_sync #(.WIDTH(5)) u_sync (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_async ({i_mode_strap_and_register_clear, i_serial_clock_or_retime_phase,
               i_format_data_in, i_select_or_shutdown_pin, i_data_qualify_clock}),
    .o_level (pins)
  );
  assign {strap, sclk, sdi, csn, dqclk} = pins;

  // offset binary to twos complement is a flip of the top bit
  function automatic logic [WORD_W-1:0] to_binary(input logic [WORD_W-1:0] w,
                                                  input logic twos);
    to_binary = twos ? {~w[WORD_W-1], w[WORD_W-2:0]} : w;
  endfunction : to_binary

  // ----------------------------------------------------------------
  // serial port state: shift register, bit counter, control register
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_READ} dmc_sp_t;
  localparam int CNT_W = $clog2(dmc_pkg::FRAME_W + 1);
  localparam int HDR_W = dmc_pkg::FRAME_W - dmc_pkg::SDATA_W;

  dmc_sp_t                         st_q, st_d;
  logic [CNT_W-1:0]                cnt_q, cnt_d;
  logic [dmc_pkg::FRAME_W-1:0]     sh_q, sh_d;
  logic [dmc_pkg::SDATA_W-1:0]     ctrl_q, ctrl_d, rd_q, rd_d;
  logic                            sclk_q, strap_q, sdo_q, sdo_d, oe_n_q, oe_n_d;
  logic                            serial_mode, rise, fall;

  assign serial_mode = !strap;                     // see R01
  assign rise        = sclk && !sclk_q;             // see R04
  assign fall        = !sclk && sclk_q;

  // frame: rw bit, two length bits, address, then data msb first
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ctrl_d = ctrl_q;
    rd_d   = rd_q;
    sdo_d  = sdo_q;
    oe_n_d = oe_n_q;
    if (!serial_mode || csn) begin                 // see R06
      st_d   = ST_IDLE;
      cnt_d  = '0;
      oe_n_d = 1'b1;
    end else begin
      case (st_q)
        ST_IDLE, ST_SHIFT: begin
          st_d = ST_SHIFT;
          if (rise) begin
            sh_d  = {sh_q[dmc_pkg::FRAME_W-2:0], sdi};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(HDR_W - 1) && sh_q[HDR_W-2]) begin
              st_d = ST_READ;                      // see R05
              rd_d = (sh_d[dmc_pkg::ADDR_W-1:0] == dmc_pkg::CTRL_ADDR) ? ctrl_q : '0;
            end
            // on the last rise the rw bit sits at the top of the shifted bits
            if (cnt_q == CNT_W'(dmc_pkg::FRAME_W - 1) &&
                sh_q[dmc_pkg::FRAME_W-2] == 1'b0 &&
                sh_q[dmc_pkg::SDATA_W+dmc_pkg::ADDR_W-2 -: dmc_pkg::ADDR_W]
                  == dmc_pkg::CTRL_ADDR) begin
              ctrl_d = {sh_q[dmc_pkg::SDATA_W-2:0], sdi} & dmc_pkg::CTRL_MASK;
            end
          end
        end
        ST_READ: begin
          if (fall) begin                          // device drives, host released
            oe_n_d = 1'b0;
            sdo_d  = rd_q[dmc_pkg::SDATA_W-1];
            rd_d   = {rd_q[dmc_pkg::SDATA_W-2:0], 1'b0};
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    // a high strap is seen only as pin mode, so its rise marks the clear pulse
    if (strap && !strap_q) begin
      ctrl_d = dmc_pkg::CTRL_RESET;                // see R03
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      ctrl_q  <= dmc_pkg::CTRL_RESET;
      rd_q    <= '0;
      sdo_q   <= 1'b0;
      oe_n_q  <= 1'b1;
      sclk_q  <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ctrl_q  <= ctrl_d;
      rd_q    <= rd_d;
      sdo_q   <= sdo_d;
      oe_n_q  <= oe_n_d;
      sclk_q  <= sclk;
      strap_q <= strap;
    end
  end

  assign o_format_data_out  = sdo_q;
  assign o_format_data_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // effective settings, retime trigger, data path
  // ----------------------------------------------------------------
  logic              phase, twos, pdn, trig_d, trig_q, ph_q, dq_q;
  logic [WORD_W-1:0] word_q, word_d, t_q, t_d;

  // serial mode takes registers, pin mode takes pin levels
  assign phase = serial_mode ? ctrl_q[dmc_pkg::CTRL_PHASE_B] : sclk;  // see R17, R09
  assign twos  = serial_mode ? ctrl_q[dmc_pkg::CTRL_FMT_B]   : sdi;   // see R10, R11
  assign pdn   = serial_mode ? ctrl_q[dmc_pkg::CTRL_PDN_B]   : csn;   // see R12

  always_comb begin
    trig_d = !serial_mode && phase && !ph_q;       // see R08
    // word captured on qualify-clock rise; power-down freezes it
    word_d = (dqclk && !dq_q && !pdn) ? i_parallel_word : word_q;  // see R15
    t_d    = pdn ? '0 : to_binary(word_q, twos);   // sampled into outputs, see R16
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      trig_q <= 1'b0;
      ph_q   <= 1'b0;
      dq_q   <= 1'b0;
      word_q <= '0;
      t_q    <= '0;
    end else begin
      trig_q <= trig_d;
      ph_q   <= phase;
      dq_q   <= dqclk;
      word_q <= word_d;
      t_q    <= t_d;
    end
  end

  assign o_i_channel_true_output       = t_q;             // see R13
  assign o_i_channel_complement_output = ~t_q;            // see R14
  assign o_pin_strap_operation         = !serial_mode;    // see R02
  assign o_retime_phase                = phase;
  assign o_twos_complement             = twos;
  assign o_shutdown                    = pdn;
  assign o_retime_trigger              = trig_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  mode_follows_strap_a: assert property ($changed(i_mode_strap_and_register_clear) |-> // see R01
    ##4 o_pin_strap_operation == $past(i_mode_strap_and_register_clear, 4))
    else $error("mode does not follow strap");
  read_drives_line_a: assert property (  // see R05
    serial_mode && !csn && st_q == ST_READ && fall |=> !o_format_data_oe_n)
    else $error("read data not driven on serial clock fall");
  outputs_complement_a: assert property (
    (o_i_channel_true_output ^ o_i_channel_complement_output) == '1)  // see R14
    else $error("outputs not complementary");
  serial_idle_release_a: assert property (csn |=> o_format_data_oe_n)  // see R06
    else $error("data line driven while deselected");
  pin_mode_release_a: assert property (strap |=> o_format_data_oe_n)  // see R02
    else $error("data line driven in pin mode");
  trigger_on_rise_a: assert property (
    strap && $rose(phase) |=> o_retime_trigger)  // see R08
    else $error("retime trigger missing");
  trigger_pulse_a: assert property (o_retime_trigger |=> !o_retime_trigger)  // see R08
    else $error("retime trigger longer than one cycle");
  shutdown_zero_a: assert property (pdn |=> o_i_channel_true_output == '0)  // see R12
    else $error("output not quiet in shutdown");
  pin_format_a: assert property (strap |-> o_twos_complement == sdi)  // see R11
    else $error("format not taken from pin");
  strap_pulse_clear_a: assert property (
    !strap_q && strap |=> ctrl_q == dmc_pkg::CTRL_RESET)  // see R03
    else $error("registers not cleared by strap pulse");

  read_seen_c:   cover property (!o_format_data_oe_n);
  trigger_c:     cover property (o_retime_trigger);
  shutdown_c:    cover property (o_shutdown && !strap);
  full_scale_c:  cover property (o_i_channel_true_output == '1);
  ctrl_write_c:  cover property (ctrl_q != dmc_pkg::CTRL_RESET);
endmodule : dmc_ctrl

// ==== tb/dmc_host.sv ====
// host model driving the shared serial pins of the control block
`timescale 1ns/1ps
module dmc_host (
  input  wire logic i_clock,
  input  wire logic i_line,
  output logic      o_sclk,
  output logic      o_sel_n,
  output logic      o_sdo,
  output logic      o_drive
);
  // idle: serial clock still, select high, line released
  initial begin
    o_sclk  = 1'b0;
    o_sel_n = 1'b1;
    o_sdo   = 1'b0;
    o_drive = 1'b0;
  end

  // one 16-bit frame, msb first; slow clock so the pin synchronisers keep up
  task automatic frame(input logic rd, input logic [4:0] addr,
                       input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] f;
    f = {rd, 2'b00, addr, wdat};
    @(negedge i_clock);
    o_sel_n = 1'b0;
    for (int b = 15; b >= 0; b--) begin
      @(negedge i_clock);
      o_sclk  = 1'b0;
      o_drive = !(rd && b < 8);  // let go before read data
      o_sdo   = f[b];
      repeat (5) @(negedge i_clock);
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clock);
      if (b < 8) rdat[b] = i_line;  // sampled late in the bit, after the device settled
    end
    o_sclk = 1'b0;
    repeat (8) @(negedge i_clock);
    o_sel_n = 1'b1;
    o_drive = 1'b0;
    repeat (8) @(negedge i_clock);
  endtask : frame
endmodule : dmc_host

// ==== tb/tb.sv ====
// self-checking bench for the converter control-pin block
`timescale 1ns/1ps
module tb;
  logic       i_clock, i_nrst, strap, phase_pin, fmt_pin, pd_pin, qclk, tog;
  logic       sclk, sel_n, sdo, drive, sdo_dev, oe_n, pin_op, rphase, twos, shut, trig;
  logic [9:0] word, tru, cmp;
  logic [7:0] rd;
  logic       line;
  int         error_cnt, checks_done, n;

  // shared pins: strap picks who owns them; a released line keeps toggling
  assign line = strap ? fmt_pin : (!oe_n ? sdo_dev : (drive ? sdo : tog));

  dmc_ctrl i_dmc_ctrl (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_mode_strap_and_register_clear(strap),
    .i_serial_clock_or_retime_phase(strap ? phase_pin : sclk),
    .i_format_data_in(line), .o_format_data_out(sdo_dev), .o_format_data_oe_n(oe_n),
    .i_select_or_shutdown_pin(strap ? pd_pin : sel_n), .i_data_qualify_clock(qclk),
    .i_parallel_word(word), .o_i_channel_true_output(tru),
    .o_i_channel_complement_output(cmp), .o_pin_strap_operation(pin_op),
    .o_retime_phase(rphase), .o_twos_complement(twos), .o_shutdown(shut),
    .o_retime_trigger(trig));
  dmc_host u_host (.i_clock(i_clock), .i_line(line), .o_sclk(sclk),
    .o_sel_n(sel_n), .o_sdo(sdo), .o_drive(drive));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) tog <= (tog !== 1'b1);

  function automatic logic [9:0] exp_word(logic [9:0] w, logic f, logic p);
    return p ? 10'h000 : {w[9] ^ f, w[8:0]};
  endfunction : exp_word

  task automatic chk_w(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b

  // one word in pin mode: settle, qualify edge, then compare both outputs
  task automatic send(input logic [9:0] w, input logic f, input logic p);
    @(negedge i_clock);
    word    = w;
    fmt_pin = f;
    pd_pin  = p;
    qclk    = 1'b0;
    repeat (6) @(negedge i_clock);
    qclk = 1'b1;
    repeat (8) @(negedge i_clock);
    chk_w(tru, exp_word(w, f, p));
    chk_w(cmp, ~exp_word(w, f, p));
    chk_b(shut, p);
    chk_b(twos, f);
  endtask : send

  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // watchdog: tests need well under 10000 cycles
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_nrst, phase_pin, fmt_pin, pd_pin, qclk, word} = '0;
    strap = 1'b1;
    void'($urandom(32'h29c4));
    repeat (5) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (8) @(negedge i_clock);
    chk_b(pin_op, 1'b1);
    send(10'h3FF, 1'b0, 1'b0);
    send(10'h000, 1'b0, 1'b0);
    send(10'h200, 1'b1, 1'b0);
    send(10'h155, 1'b1, 1'b1);
    for (int i = 0; i < 20; i++) send(10'($urandom), 1'($urandom), ($urandom % 4) == 0);
    $display("test pin_mode done");
    // retime edge: exactly one pulse per rising edge of the phase pin
    n = 0;
    @(negedge i_clock);
    phase_pin = 1'b1;
    repeat (12) begin
      @(negedge i_clock);
      if (trig === 1'b1) n++;
    end
    chk_w(n[9:0], 10'h001);
    chk_b(rphase, 1'b1);
    phase_pin = 1'b0;
    $display("test retime done");
    // serial mode: registers own the settings, pins carry the port
    strap = 1'b0;
    repeat (8) @(negedge i_clock);
    chk_b(pin_op, 1'b0);
    u_host.frame(1'b0, dmc_pkg::CTRL_ADDR, 8'h07, rd);
    repeat (8) @(negedge i_clock);
    chk_b(twos, 1'b1);
    chk_b(shut, 1'b1);
    chk_b(rphase, 1'b1);
    u_host.frame(1'b1, dmc_pkg::CTRL_ADDR, 8'h00, rd);
    chk_w({2'b00, rd}, 10'h007);
    u_host.frame(1'b1, 5'h1F, 8'h00, rd);
    chk_w({2'b00, rd}, 10'h000);
    n = $urandom;
    u_host.frame(1'b0, dmc_pkg::CTRL_ADDR, n[7:0], rd);
    u_host.frame(1'b1, dmc_pkg::CTRL_ADDR, 8'h00, rd);
    chk_w({2'b00, rd}, {2'b00, n[7:0] & dmc_pkg::CTRL_MASK});
    strap = 1'b1;  // clearing pulse on the strap
    repeat (8) @(negedge i_clock);
    strap = 1'b0;
    repeat (8) @(negedge i_clock);
    u_host.frame(1'b1, dmc_pkg::CTRL_ADDR, 8'h00, rd);
    chk_w({2'b00, rd}, {2'b00, dmc_pkg::CTRL_RESET});
    $display("test serial_mode done");
    results();
  end
endmodule : tb
